// ---- verilog/rqt_defines.svh ----
`ifndef RQT_DEFINES_SVH
`define RQT_DEFINES_SVH

// Stream geometry
`define RQT_DATA_W 256
`define RQT_SIDEBAND_W 60
`define RQT_TAG_W 6
`define RQT_FIRST_DWORD_BYTE_ENABLES_LSB 0
`define RQT_FINAL_DWORD_BYTE_ENABLES_LSB 4
`define RQT_BE_W 4

// Request type field in the descriptor and its codes; all but memory write need a completion
`define RQT_REQ_TYPE_LSB 75
`define RQT_REQ_TYPE_W 4
`define RQT_TYPE_MEM_RD 4'h0
`define RQT_TYPE_MEM_WR 4'h1
`define RQT_TYPE_IO_RD 4'h2
`define RQT_TYPE_IO_WR 4'h3
`define RQT_TYPE_MEM_FETCH_ADD 4'h4
`define RQT_TYPE_MEM_SWAP 4'h5
`define RQT_TYPE_MEM_CAS 4'h6
`define RQT_TYPE_LOCK_RD 4'h7
`define RQT_TYPE_CFG0_RD 4'h8
`define RQT_TYPE_CFG1_RD 4'h9
`define RQT_TYPE_CFG0_WR 4'hA
`define RQT_TYPE_CFG1_WR 4'hB

// Report queue and latency
`define RQT_QUEUE_DEPTH 4
`define RQT_PTR_W 2
`define RQT_CNT_W 3
`define RQT_CLK_PERIOD_NS 20
`define RQT_REPORT_LAT_NS 60
`define RQT_REPORT_LAT_CYC ((`RQT_REPORT_LAT_NS + `RQT_CLK_PERIOD_NS - 1) / `RQT_CLK_PERIOD_NS)
`define RQT_AGE_W 4

// Register port
`define RQT_ADDR_W 8
`define RQT_REG_W 32
`define RQT_OFS_CTRL 8'h00
`define RQT_OFS_STATUS 8'h04
`define RQT_OFS_NP_COUNT 8'h08
`define RQT_OFS_DROP_COUNT 8'h0C
`define RQT_CTRL_USER_TAG_BIT 0
`define RQT_CTRL_RESET 32'h0000_0000
`define RQT_CNT16_W 16

`endif

// ---- verilog/rqt_pkg.sv ----
package rqt_pkg;
  // Packet framing on the request stream
  typedef enum logic [0:0] {
    RQT_IDLE = 1'b0,
    RQT_IN_PKT = 1'b1
  } rqt_pkt_state_type;
endpackage

// ---- verilog/rqt_tag_if.sv ----
`include "rqt_defines.svh"
interface rqt_tag_if;
  logic alloc_req;
  logic push;
  logic [`RQT_TAG_W-1:0] push_tag;
  logic full;
  logic report_valid;
  logic [`RQT_TAG_W-1:0] report_tag;
  logic [`RQT_CNT_W-1:0] count;

  modport alloc (input alloc_req, output push, output push_tag);
  modport queue (input push, input push_tag, output full, output report_valid,
                 output report_tag, output count);
  modport front (output alloc_req, input full, input report_valid, input report_tag,
                 input count);
endinterface

// ---- verilog/rqt_tag_alloc.sv ----
`include "rqt_defines.svh"
module rqt_tag_alloc (
  input wire logic mclk,
  input wire logic rst_n,
  rqt_tag_if.alloc a
);
  logic [`RQT_TAG_W-1:0] next_tag;

  // Rolling tag counter; the front only requests while the queue has room
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      next_tag <= 6'h00;
    end else if (a.alloc_req) begin
      next_tag <= next_tag + 6'h01;
    end
  end

  // Tag handed to the queue in the accepting cycle
  assign a.push = a.alloc_req;
  assign a.push_tag = next_tag;
endmodule

// ---- verilog/rqt_report_queue.sv ----
`include "rqt_defines.svh"
module rqt_report_queue (
  input wire logic mclk,
  input wire logic rst_n,
  rqt_tag_if.queue q
);
  logic [`RQT_TAG_W-1:0] entry [0:`RQT_QUEUE_DEPTH-1];
  logic [`RQT_PTR_W-1:0] wr_ptr;
  logic [`RQT_PTR_W-1:0] rd_ptr;
  logic [`RQT_CNT_W-1:0] count;
  logic [`RQT_AGE_W-1:0] age;
  logic pop;
  logic do_push;
  logic valid_q;
  logic [`RQT_TAG_W-1:0] tag_q;

  // Head leaves once it has waited the report latency
  assign pop = (count != 3'h0) && (age >= 4'(`RQT_REPORT_LAT_CYC - 1));
  assign do_push = q.push && (count != 3'(`RQT_QUEUE_DEPTH));

  // One flop group per entry, written at the write pointer
  genvar i;
  generate
    for (i = 0; i < `RQT_QUEUE_DEPTH; i = i + 1) begin : g_entry
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          entry[i] <= 6'h00;
        end else if (do_push && (wr_ptr == 2'(i))) begin
          entry[i] <= q.push_tag;
        end
      end
    end
  endgenerate

  // Pointers and fill level; strict FIFO order
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 2'h0;
      rd_ptr <= 2'h0;
      count <= 3'h0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 2'h1;
      end
      count <= count + 3'(do_push) - 3'(pop);
    end
  end

  // Age of the current head, restarted when a new head takes its place
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age <= 4'h0;
    end else if (pop || count == 3'h0) begin
      age <= 4'h0;
    end else if (age != 4'hF) begin
      age <= age + 4'h1;
    end
  end

  // Report outputs; tag forced to zero outside the pulse so stale values never leak
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      tag_q <= 6'h00;
    end else begin
      valid_q <= pop;
      tag_q <= pop ? entry[rd_ptr] : 6'h00;
    end
  end

  assign q.report_valid = valid_q;
  assign q.report_tag = tag_q;
  assign q.full = (count == 3'(`RQT_QUEUE_DEPTH));
  assign q.count = count;
endmodule

// ---- verilog/rqt_request_front.sv ----
`include "rqt_defines.svh"
module rqt_request_front (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`RQT_DATA_W-1:0] request_stream_data,
  input wire logic [`RQT_SIDEBAND_W-1:0] request_sideband_bus,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  output logic request_stream_ready,
  output logic [`RQT_TAG_W-1:0] np_tag_report_bus,
  output logic np_tag_report_valid,
  output logic [`RQT_BE_W-1:0] first_dword_byte_enables,
  output logic [`RQT_BE_W-1:0] final_dword_byte_enables,
  input wire logic [`RQT_ADDR_W-1:0] reg_addr,
  input wire logic [`RQT_REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`RQT_REG_W-1:0] reg_rdata
);
  rqt_tag_if tag_link ();

  rqt_pkg::rqt_pkt_state_type pkt_state;
  rqt_pkg::rqt_pkt_state_type next_pkt_state;
  logic user_tag_mgmt_setting;
  logic beat_taken;
  logic first_beat;
  logic [`RQT_REQ_TYPE_W-1:0] req_type;
  logic is_non_posted;
  logic [`RQT_CNT16_W-1:0] np_count;
  logic [`RQT_CNT16_W-1:0] user_tag_count;
  logic [`RQT_REG_W-1:0] next_rdata;
  logic [`RQT_REG_W-1:0] rdata_q;

  rqt_tag_alloc u_alloc (
    .mclk(mclk),
    .rst_n(rst_n),
    .a(tag_link)
  );

  rqt_report_queue u_queue (
    .mclk(mclk),
    .rst_n(rst_n),
    .q(tag_link)
  );

  // Back-pressure while no report slot is free, so no allocated tag is lost
  assign request_stream_ready = !tag_link.full;
  assign beat_taken = request_stream_valid && request_stream_ready;
  assign first_beat = beat_taken && (pkt_state == rqt_pkg::RQT_IDLE);

  // Descriptor type of the packet now starting
  assign req_type = request_stream_data[`RQT_REQ_TYPE_LSB +: `RQT_REQ_TYPE_W];

  // Requests that expect a completion take a tag
  always_comb begin
    case (req_type)
      `RQT_TYPE_MEM_RD,
      `RQT_TYPE_IO_RD,
      `RQT_TYPE_IO_WR,
      `RQT_TYPE_MEM_FETCH_ADD,
      `RQT_TYPE_MEM_SWAP,
      `RQT_TYPE_MEM_CAS,
      `RQT_TYPE_LOCK_RD,
      `RQT_TYPE_CFG0_RD,
      `RQT_TYPE_CFG1_RD,
      `RQT_TYPE_CFG0_WR,
      `RQT_TYPE_CFG1_WR: is_non_posted = 1'b1;
      default: is_non_posted = 1'b0;
    endcase
  end

  // Allocate only when the core owns tags and a Non-Posted packet starts
  assign tag_link.alloc_req = first_beat && is_non_posted && !user_tag_mgmt_setting;

  // Packet framing: first beat opens, last beat closes
  always_comb begin
    next_pkt_state = pkt_state;
    case (pkt_state)
      rqt_pkg::RQT_IDLE: begin
        if (beat_taken && !request_stream_last) begin
          next_pkt_state = rqt_pkg::RQT_IN_PKT;
        end
      end
      rqt_pkg::RQT_IN_PKT: begin
        if (beat_taken && request_stream_last) begin
          next_pkt_state = rqt_pkg::RQT_IDLE;
        end
      end
      default: next_pkt_state = rqt_pkg::RQT_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_state <= rqt_pkg::RQT_IDLE;
    end else begin
      pkt_state <= next_pkt_state;
    end
  end

  // Byte enables held from the first beat; later beats cannot disturb them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_dword_byte_enables <= 4'h0;
      final_dword_byte_enables <= 4'h0;
    end else if (first_beat) begin
      first_dword_byte_enables <= request_sideband_bus[`RQT_FIRST_DWORD_BYTE_ENABLES_LSB +: `RQT_BE_W];
      final_dword_byte_enables <= request_sideband_bus[`RQT_FINAL_DWORD_BYTE_ENABLES_LSB +: `RQT_BE_W];
    end
  end

  // Tag reports straight from the queue flops
  assign np_tag_report_bus = tag_link.report_tag;
  assign np_tag_report_valid = tag_link.report_valid;

  // Control register; the setting only takes effect at the next packet start
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      user_tag_mgmt_setting <= 1'(`RQT_CTRL_RESET);
    end else if (reg_wr && (reg_addr == `RQT_OFS_CTRL)) begin
      user_tag_mgmt_setting <= reg_wdata[`RQT_CTRL_USER_TAG_BIT];
    end
  end

  // Non-Posted counters; wrap silently, software reads differences
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      np_count <= 16'h0000;
      user_tag_count <= 16'h0000;
    end else if (first_beat && is_non_posted) begin
      if (user_tag_mgmt_setting) begin
        user_tag_count <= user_tag_count + 16'h0001;
      end else begin
        np_count <= np_count + 16'h0001;
      end
    end
  end

  // Read decode; unmapped offsets read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_addr == `RQT_OFS_CTRL) begin
      next_rdata[`RQT_CTRL_USER_TAG_BIT] = user_tag_mgmt_setting;
    end else if (reg_addr == `RQT_OFS_STATUS) begin
      next_rdata[3:0] = first_dword_byte_enables;
      next_rdata[7:4] = final_dword_byte_enables;
      next_rdata[10:8] = tag_link.count;
      next_rdata[11] = tag_link.full;
      next_rdata[12] = (pkt_state == rqt_pkg::RQT_IN_PKT);
    end else if (reg_addr == `RQT_OFS_NP_COUNT) begin
      next_rdata[15:0] = np_count;
    end else if (reg_addr == `RQT_OFS_DROP_COUNT) begin
      next_rdata[15:0] = user_tag_count;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      rdata_q <= next_rdata;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_q;
endmodule

// ---- tb/rqt_request_front_asserts.sv ----
`include "rqt_defines.svh"
module rqt_front_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [`RQT_DATA_W-1:0] request_stream_data,
  input wire logic [`RQT_SIDEBAND_W-1:0] request_sideband_bus,
  input wire logic request_stream_last,
  input wire logic request_stream_valid,
  input wire logic request_stream_ready,
  input wire logic [`RQT_TAG_W-1:0] np_tag_report_bus,
  input wire logic np_tag_report_valid,
  input wire logic [`RQT_BE_W-1:0] first_dword_byte_enables,
  input wire logic [`RQT_BE_W-1:0] final_dword_byte_enables,
  input wire logic [`RQT_ADDR_W-1:0] reg_addr,
  input wire logic [`RQT_REG_W-1:0] reg_wdata,
  input wire logic reg_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic in_pkt, user_tag, first, np_new;
  logic [3:0] typ;
  logic [2:0] pend;
  logic [`RQT_TAG_W-1:0] exp_tag;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Packet start, and whether it owes a tag
  assign typ = request_stream_data[`RQT_REQ_TYPE_LSB +: `RQT_REQ_TYPE_W];
  assign first = request_stream_valid && request_stream_ready && !in_pkt;
  assign np_new = first && !user_tag && typ != `RQT_TYPE_MEM_WR && typ <= `RQT_TYPE_CFG1_WR;
  // Framing, setting, outstanding reports, next tag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      in_pkt <= 1'b0;
      user_tag <= 1'b0;
      pend <= 3'h0;
      exp_tag <= '0;
    end else begin
      if (request_stream_valid && request_stream_ready) in_pkt <= !request_stream_last;
      if (reg_wr && reg_addr == `RQT_OFS_CTRL) user_tag <= reg_wdata[`RQT_CTRL_USER_TAG_BIT];
      pend <= pend + {2'h0, np_new} - {2'h0, np_tag_report_valid};
      if (np_tag_report_valid) exp_tag <= exp_tag + 1'b1;
    end
  end
  // Quiet gap that follows every report
  sequence s_gap;
    !np_tag_report_valid [*2];
  endsequence
  sequence s_np_alone;
    np_new && pend == 3'h0;
  endsequence
  // Pulse rises three edges after the accepting edge, so it is sampled on the fourth
  chk_first_latency: assert property (s_np_alone |=> !np_tag_report_valid ##1 s_gap
    ##1 np_tag_report_valid)
    else $error("tag report not three cycles after request");
  chk_pulse_gap: assert property (np_tag_report_valid |=> s_gap)
    else $error("tag valid longer than one cycle");
  chk_idle_bus: assert property (!np_tag_report_valid |-> np_tag_report_bus == '0)
    else $error("tag bus not zero while idle");
  chk_tag_order: assert property (np_tag_report_valid |-> np_tag_report_bus == exp_tag)
    else $error("tag out of order");
  chk_report_cause: assert property (np_tag_report_valid |-> pend != 3'h0)
    else $error("tag reported with none pending");
  chk_user_quiet: assert property (first && user_tag && pend == 3'h0 |=>
    !np_tag_report_valid [*3])
    else $error("tag reported with user tags on");
  chk_be_capture: assert property (first |=>
    first_dword_byte_enables == $past(request_sideband_bus[3:0])
    && final_dword_byte_enables == $past(request_sideband_bus[7:4]))
    else $error("byte enables not captured");
  chk_be_hold: assert property (!first |=> $stable(first_dword_byte_enables)
    && $stable(final_dword_byte_enables))
    else $error("byte enables changed off first beat");
  // A report on the bus has already left the queue, so it no longer holds a slot
  chk_ready_room: assert property (request_stream_ready ==
    ((pend - {2'h0, np_tag_report_valid}) != 3'h4))
    else $error("ready disagrees with pending count");
endmodule
bind rqt_request_front rqt_front_chk u_chk (.mclk, .rst_n, .request_stream_data,
  .request_sideband_bus, .request_stream_last, .request_stream_valid, .request_stream_ready,
  .np_tag_report_bus, .np_tag_report_valid, .first_dword_byte_enables,
  .final_dword_byte_enables, .reg_addr, .reg_wdata, .reg_wr);

// ---- tb/rqt_user_app.sv ----
`include "rqt_defines.svh"
module rqt_user_app (
  input wire logic mclk,
  output logic [`RQT_DATA_W-1:0] request_stream_data,
  output logic [`RQT_SIDEBAND_W-1:0] request_sideband_bus,
  output logic request_stream_last,
  output logic request_stream_valid,
  input wire logic request_stream_ready,
  input wire logic [`RQT_TAG_W-1:0] np_tag_report_bus,
  input wire logic np_tag_report_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [`RQT_TAG_W-1:0] tags[$];
  initial begin
    request_stream_data = '0;
    request_sideband_bus = '0;
    request_stream_last = 1'b0;
    request_stream_valid = 1'b0;
  end
  // Keep every tag so later completions can be matched
  always @(posedge mclk) begin
    if (np_tag_report_valid) tags.push_back(np_tag_report_bus);
  end
  // Later beats carry flipped enables to show they are ignored
  task automatic send(input logic [3:0] typ, input logic [3:0] fbe, input logic [3:0] lbe,
                      input int beats);
    for (int i = 0; i < beats; i++) begin
      request_stream_data[`RQT_REQ_TYPE_LSB +: `RQT_REQ_TYPE_W] <= typ;
      request_sideband_bus[7:0] <= (i == 0) ? {lbe, fbe} : ~{lbe, fbe};
      request_stream_last <= (i == beats - 1);
      request_stream_valid <= 1'b1;
      do @(negedge mclk); while (!request_stream_ready);
      @(posedge mclk);
    end
  endtask
  // Released lines toggle rather than keep the last beat
  task automatic idle;
    request_stream_valid <= 1'b0;
    request_stream_last <= 1'b0;
    request_stream_data <= ~request_stream_data;
    request_sideband_bus <= ~request_sideband_bus;
  endtask
endmodule

// ---- tb/test_rqt_request_front.sv ----
`include "rqt_defines.svh"
module test_rqt_request_front;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata;
  logic [`RQT_DATA_W-1:0] request_stream_data;
  logic [`RQT_SIDEBAND_W-1:0] request_sideband_bus;
  logic request_stream_last, request_stream_valid, request_stream_ready, np_tag_report_valid;
  logic [5:0] np_tag_report_bus;
  logic [3:0] first_dword_byte_enables, final_dword_byte_enables;
  int err_total = 0, n_tests = 0, cyc = 0;
  rqt_request_front dut (.mclk, .rst_n, .request_stream_data, .request_sideband_bus,
    .request_stream_last, .request_stream_valid, .request_stream_ready, .np_tag_report_bus,
    .np_tag_report_valid, .first_dword_byte_enables, .final_dword_byte_enables, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  rqt_user_app u_app (.mclk, .request_stream_data, .request_sideband_bus,
    .request_stream_last, .request_stream_valid, .request_stream_ready,
    .np_tag_report_bus, .np_tag_report_valid);
  always #10 mclk = ~mclk;
  // Hang guard, far above the expected run
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge mclk);
    // Read data must fall back to zero once its single cycle is over
    #1 chk("rdata drop", 32'h0000_0000, reg_rdata);
  endtask
  task automatic wait_tags(input int n);
    for (int i = 0; i < 60 && u_app.tags.size() < n; i++) @(posedge mclk);
    repeat (6) @(posedge mclk);
    chk("tag count", n, u_app.tags.size());
  endtask
  task automatic t_reset;
    logic [31:0] d;
    chk("idle outputs", 32'h0000_0001, {np_tag_report_valid, first_dword_byte_enables,
      final_dword_byte_enables, request_stream_ready});
    reg_read(8'h00, d);
    chk("ctrl", 32'h0000_0000, d);
    reg_write(8'h10, 32'hFFFF_FFFF);
    reg_read(8'h10, d);
    chk("unmapped", 32'h0000_0000, d);
    $display("test reset done");
  endtask
  task automatic t_single;
    logic [31:0] d;
    u_app.send(4'h0, 4'h3, 4'h0, 1);
    u_app.idle();
    wait_tags(1);
    chk("first tag", 32'h0000_0000, u_app.tags[0]);
    reg_read(8'h04, d);
    chk("status be", 32'h0000_0003, d[7:0]);
    $display("test single done");
  endtask
  // Every type, back to back, until ready stalls the sender
  task automatic t_types;
    logic [31:0] d;
    for (int t = 0; t < 12; t++) u_app.send(t[3:0], t[3:0], ~t[3:0], 2);
    u_app.idle();
    wait_tags(12);
    for (int i = 1; i < 12; i++) chk("tag order", i, u_app.tags[i]);
    chk("be", 32'h0000_00B4, {first_dword_byte_enables, final_dword_byte_enables});
    reg_read(8'h08, d);
    chk("alloc count", 32'h0000_000C, d);
    $display("test types done");
  endtask
  task automatic t_user;
    logic [31:0] d;
    reg_write(8'h00, 32'h0000_0001);
    u_app.send(4'h8, 4'h1, 4'h0, 1);
    u_app.idle();
    wait_tags(12);
    reg_read(8'h0C, d);
    chk("user starts", 32'h0000_0001, d);
    reg_write(8'h00, 32'h0000_0000);
    u_app.send(4'h2, 4'hF, 4'h0, 1);
    u_app.idle();
    wait_tags(13);
    chk("next tag", 32'h0000_000C, u_app.tags[12]);
    $display("test user tags done");
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    t_reset;
    t_single;
    t_types;
    t_user;
    stop_test;
  end
endmodule
